/* File: verilog/sys_vec_pkg.sv */
// Package for the system reset / NMI vector generator.
// Assumes a 16-bit register port with word offsets as byte addresses.
package sys_vec_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] USER_NMI_VECTOR_ADDR = 16'h019A;
  localparam logic [15:0] SYSTEM_NMI_VECTOR_ADDR = 16'h019C;
  localparam logic [15:0] RESET_CAUSE_VECTOR_ADDR = 16'h019E;
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'h01A0;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'h01A2;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [2:0] IRQ_RESET_CAUSE_BIT = 3'h0;
  localparam logic [2:0] IRQ_SYSTEM_NMI_BIT = 3'h1;
  localparam logic [2:0] IRQ_USER_NMI_BIT = 3'h2;
  localparam logic [2:0] IRQ_RESET_VAL = 3'h0;

  // ---------------------------------------------------------------
  // Source counts and field widths
  // ---------------------------------------------------------------
  localparam int RST_N = 15;
  localparam int SNMI_N = 9;
  localparam int UNMI_N = 3;
  localparam int IRQ_N = 3;

  // Reset cause bit positions, highest priority at bit 0
  localparam int RC_BROWNOUT = 0;
  localparam int RC_PIN_RESET = 1;
  localparam int RC_SOFTWARE_BROWNOUT = 2;
  localparam int RC_DEEP_SHUTDOWN_WAKE = 3;
  localparam int RC_SECURITY = 4;
  localparam int RC_CORE_SUPERVISOR = 5;
  localparam int RC_SUPPLY_SUPERVISOR = 6;
  localparam int RC_CORE_MONITOR_OVERVOLTAGE = 7;
  localparam int RC_SUPPLY_MONITOR_OVERVOLTAGE = 8;
  localparam int RC_SOFTWARE_POWER_ON_RESET = 9;
  localparam int RC_WATCHDOG_EXPIRY = 10;
  localparam int RC_WATCHDOG_PASSWORD = 11;
  localparam int RC_FLASH_KEY_VIOLATION = 12;
  localparam int RC_PERIPHERAL_FETCH = 13;
  localparam int RC_PMM_PASSWORD = 14;

  // Reset cause codes, index by bit position
  localparam logic [15:0] RST_CODE [RST_N] = '{
    16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
    16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014,
    16'h0016, 16'h0018, 16'h001A, 16'h001E, 16'h0020
  };
  // Code 1Ch is reserved and skipped above
  localparam logic [15:0] RST_CODE_RESERVED = 16'h001C;

  // System NMI bits, highest priority at bit 0
  localparam logic [15:0] SNMI_CODE [SNMI_N] = '{
    16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
    16'h000C, 16'h000E, 16'h0010, 16'h0012
  };
  localparam int SN_MAILBOX_INPUT = 5;
  localparam int SN_MAILBOX_OUTPUT = 6;

  // User NMI bits, highest priority at bit 0
  localparam logic [15:0] UNMI_CODE [UNMI_N] = '{
    16'h0002, 16'h0004, 16'h0006
  };

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [RST_N-1:0] reset_cause;
    logic [SNMI_N-1:0] system_nmi;
    logic [UNMI_N-1:0] user_nmi;
  } src_events_t;

  typedef enum logic [2:0] {
    SEL_USER = 3'b001,
    SEL_SYSTEM = 3'b010,
    SEL_RESET = 3'b100
  } vec_sel_t;

endpackage : sys_vec_pkg

/* File: verilog/system_reset_nmi_vectors.sv */
// System reset / NMI vector generator: three read-only priority vectors.
// Assumes source event inputs are one-cycle pulses synchronous to clk_in.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) Reset-cause vector at 019Eh: 00h idle, else highest cause, 02h to 20h.
// (R2) Middle reset codes: pin 04h through supply monitor overvoltage 12h.
// (R3) Watchdog expiry 16h, watchdog password 18h, both power-up-clear class.
// (R4) Flash key violation 1Ah; code 1Ch reserved, never produced.
// (R5) Instruction fetch from peripheral area reports 1Eh.
// (R6) Power-management password fault 20h; 22h to 3Eh reserved, lowest.
// (R7) System NMI vector at 019Ch: monitor, delay, vacant memory, level codes.
// (R8) Mailbox input events 0Ch and output events 0Eh in system NMI vector.
// (R9) User NMI vector at 019Ah: pin 02h, oscillator 04h, flash access 06h.
// (R10) Reading a vector clears the reported flag; next read shows next.
module system_reset_nmi_vectors
  import sys_vec_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Source events
  input wire logic [RST_N-1:0] reset_cause_in,
  input wire logic [SNMI_N-1:0] system_nmi_in,
  input wire logic [UNMI_N-1:0] user_nmi_in,
  // Interrupt and pending levels
  output logic irq_out,
  output logic reset_pending_out,
  output logic system_nmi_pending_out,
  output logic user_nmi_pending_out
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg_req_t req;
  src_events_t ev;
  logic [RST_N-1:0] rst_flag_r;
  logic [SNMI_N-1:0] snmi_flag_r;
  logic [UNMI_N-1:0] unmi_flag_r;
  logic [IRQ_N-1:0] irq_status_r;
  logic [IRQ_N-1:0] irq_mask_r;
  logic [15:0] rst_code;
  logic [15:0] snmi_code;
  logic [15:0] unmi_code;
  logic [RST_N-1:0] rst_clr;
  logic [SNMI_N-1:0] snmi_clr;
  logic [UNMI_N-1:0] unmi_clr;
  logic [IRQ_N-1:0] irq_set;
  vec_sel_t sel;
  logic sel_valid;
  logic [15:0] rdata_nxt;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign ev = '{reset_cause: reset_cause_in, system_nmi: system_nmi_in,
                user_nmi: user_nmi_in};

  // ---------------------------------------------------------------
  // Vector read decode
  // ---------------------------------------------------------------
  // Select which vector a read targets; only valid with a read strobe
  always_comb begin
    sel = SEL_USER;
    sel_valid = 1'b0;
    if (req.rd) begin
      if (req.addr == USER_NMI_VECTOR_ADDR) begin
        sel = SEL_USER;
        sel_valid = 1'b1;
      end else if (req.addr == SYSTEM_NMI_VECTOR_ADDR) begin
        sel = SEL_SYSTEM;
        sel_valid = 1'b1;
      end else if (req.addr == RESET_CAUSE_VECTOR_ADDR) begin
        sel = SEL_RESET;
        sel_valid = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Priority encoders
  // ---------------------------------------------------------------
  // (R1) reset cause priority
  // Lowest bit wins, so scan downward and let the last hit stand
  always_comb begin
    rst_code = VEC_NONE;
    rst_clr = '0;
    for (int i = RST_N - 1; i >= 0; i--) begin
      if (rst_flag_r[i]) begin
        // (R2) (R3) (R4) (R5) (R6) codes from table
        rst_code = RST_CODE[i];
        rst_clr = '0;
        rst_clr[i] = 1'b1;
      end
    end
  end

  // (R7) system NMI priority
  always_comb begin
    snmi_code = VEC_NONE;
    snmi_clr = '0;
    for (int i = SNMI_N - 1; i >= 0; i--) begin
      if (snmi_flag_r[i]) begin
        // (R8) mailbox codes included
        snmi_code = SNMI_CODE[i];
        snmi_clr = '0;
        snmi_clr[i] = 1'b1;
      end
    end
  end

  // (R9) user NMI priority
  always_comb begin
    unmi_code = VEC_NONE;
    unmi_clr = '0;
    for (int i = UNMI_N - 1; i >= 0; i--) begin
      if (unmi_flag_r[i]) begin
        unmi_code = UNMI_CODE[i];
        unmi_clr = '0;
        unmi_clr[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Source flags
  // ---------------------------------------------------------------
  // (R10) read clears reported flag
  // A new event on the same cycle as the clearing read wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_flag_r <= '0;
    end else if (clk_en_in) begin
      if (sel_valid && sel == SEL_RESET) begin
        rst_flag_r <= (rst_flag_r & ~rst_clr) | ev.reset_cause;
      end else begin
        rst_flag_r <= rst_flag_r | ev.reset_cause;
      end
    end
  end

  // (R10) system NMI flag clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snmi_flag_r <= '0;
    end else if (clk_en_in) begin
      if (sel_valid && sel == SEL_SYSTEM) begin
        snmi_flag_r <= (snmi_flag_r & ~snmi_clr) | ev.system_nmi;
      end else begin
        snmi_flag_r <= snmi_flag_r | ev.system_nmi;
      end
    end
  end

  // (R10) user NMI flag clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unmi_flag_r <= '0;
    end else if (clk_en_in) begin
      if (sel_valid && sel == SEL_USER) begin
        unmi_flag_r <= (unmi_flag_r & ~unmi_clr) | ev.user_nmi;
      end else begin
        unmi_flag_r <= unmi_flag_r | ev.user_nmi;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // Any new event in a group sets that group's sticky status bit
  assign irq_set = {|ev.user_nmi, |ev.system_nmi, |ev.reset_cause};

  // Write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_r <= IRQ_RESET_VAL;
    end else if (clk_en_in) begin
      if (req.wr && req.addr == IRQ_STATUS_ADDR) begin
        irq_status_r <= (irq_status_r & ~req.wdata[IRQ_N-1:0]) | irq_set;
      end else begin
        irq_status_r <= irq_status_r | irq_set;
      end
    end
  end

  // Mask register: a one lets the status bit reach the interrupt line
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= IRQ_RESET_VAL;
    end else if (clk_en_in && req.wr && req.addr == IRQ_MASK_ADDR) begin
      irq_mask_r <= req.wdata[IRQ_N-1:0];
    end
  end

  // Registered interrupt keeps the output glitch-free, at one cycle lag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(irq_status_r & irq_mask_r);
    end
  end

  // Pending levels follow the flag registers one cycle later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_pending_out <= 1'b0;
      system_nmi_pending_out <= 1'b0;
      user_nmi_pending_out <= 1'b0;
    end else if (clk_en_in) begin
      reset_pending_out <= |rst_flag_r;
      system_nmi_pending_out <= |snmi_flag_r;
      user_nmi_pending_out <= |unmi_flag_r;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    rdata_nxt = VEC_NONE;
    if (req.rd) begin
      unique case (req.addr)
        USER_NMI_VECTOR_ADDR: rdata_nxt = unmi_code;
        SYSTEM_NMI_VECTOR_ADDR: rdata_nxt = snmi_code;
        RESET_CAUSE_VECTOR_ADDR: rdata_nxt = rst_code;
        IRQ_STATUS_ADDR: rdata_nxt = {{(16-IRQ_N){1'b0}}, irq_status_r};
        IRQ_MASK_ADDR: rdata_nxt = {{(16-IRQ_N){1'b0}}, irq_mask_r};
        default: rdata_nxt = VEC_NONE;
      endcase
    end
  end

  // Read data stands in the cycle after the read strobe, and holds while clk_en_in is low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= VEC_NONE;
    end else if (clk_en_in) begin
      rdata_out <= rdata_nxt;
    end
  end

endmodule : system_reset_nmi_vectors

`default_nettype wire

/* File: dv/system_reset_nmi_vectors_checker.sv */
// Checker for the system reset / NMI vector generator.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module system_reset_nmi_vectors_checker
  import sys_vec_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  // Events and levels
  input wire logic [RST_N-1:0] reset_cause_in,
  input wire logic [SNMI_N-1:0] system_nmi_in,
  input wire logic [UNMI_N-1:0] user_nmi_in,
  input wire logic irq_out,
  input wire logic reset_pending_out,
  input wire logic system_nmi_pending_out,
  input wire logic user_nmi_pending_out
);
  // ---------------------------------------------------------------
  // Vector reads
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Taken reads, one per vector
  wire logic rd_rc = clk_en_in && rd_in && addr_in == RESET_CAUSE_VECTOR_ADDR;
  wire logic rd_sn = clk_en_in && rd_in && addr_in == SYSTEM_NMI_VECTOR_ADDR;
  wire logic rd_un = clk_en_in && rd_in && addr_in == USER_NMI_VECTOR_ADDR;

  rdata_idle_a: assert property ($past(!rd_in && clk_en_in) |-> rdata_out == VEC_NONE)
    else $error("read data not zero without a read");
  reset_range_a: assert property (rd_rc |=>
    !rdata_out[0] && rdata_out != 16'h001C && rdata_out <= 16'h0020)
    else $error("reset vector gave a reserved code");
  snmi_range_a: assert property (rd_sn |=> !rdata_out[0] && rdata_out <= 16'h0012)
    else $error("system vector gave a reserved code");
  unmi_range_a: assert property (rd_un |=> !rdata_out[0] && rdata_out <= 16'h0006)
    else $error("user vector gave a reserved code");
  reset_prio_a: assert property ((clk_en_in && reset_cause_in[0]) ##1 rd_rc |=>
    rdata_out == 16'h0002)
    else $error("brownout not reported first");
  snmi_prio_a: assert property ((clk_en_in && system_nmi_in[0]) ##1 rd_sn |=>
    rdata_out == 16'h0002)
    else $error("core monitor not reported first");
  unmi_prio_a: assert property ((clk_en_in && user_nmi_in[0]) ##1 rd_un |=>
    rdata_out == 16'h0002)
    else $error("pin event not reported first");
  pending_seen_a: assert property ((clk_en_in && |reset_cause_in) ##1 clk_en_in |=>
    reset_pending_out)
    else $error("reset cause not pending");
  snmi_pending_a: assert property ((clk_en_in && |system_nmi_in) ##1 clk_en_in |=>
    system_nmi_pending_out)
    else $error("system NMI not pending");
  unmi_pending_a: assert property ((clk_en_in && |user_nmi_in) ##1 clk_en_in |=>
    user_nmi_pending_out)
    else $error("user NMI not pending");
  enable_freeze_a: assert property (!clk_en_in |=> $stable(rdata_out) && $stable(irq_out))
    else $error("outputs moved while disabled");

  // Main scenarios reached
  cover property (rd_rc ##1 rdata_out == 16'h0020);
  cover property (rd_sn ##1 rdata_out == 16'h000E);
  cover property ($rose(irq_out));
endmodule : system_reset_nmi_vectors_checker

bind system_reset_nmi_vectors system_reset_nmi_vectors_checker checker_inst (
  .clk_in, .rst_n_in, .clk_en_in, .addr_in, .rd_in, .rdata_out, .reset_cause_in,
  .system_nmi_in, .user_nmi_in, .irq_out, .reset_pending_out, .system_nmi_pending_out,
  .user_nmi_pending_out
);
`default_nettype wire

/* File: dv/system_reset_nmi_vectors_bench.sv */
// Testbench for the system reset / NMI vector generator.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module system_reset_nmi_vectors_bench
  import sys_vec_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic clk_in, rst_n_in, clk_en_in, wr_in, rd_in, irq_out;
  logic reset_pending_out, system_nmi_pending_out, user_nmi_pending_out;
  logic rd_d = 1'b0;
  logic [15:0] addr_in, wdata_in, rdata_out, e;
  logic [RST_N-1:0] reset_cause_in;
  logic [SNMI_N-1:0] system_nmi_in;
  logic [UNMI_N-1:0] user_nmi_in;
  logic [15:0] exp_q [$];
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'ha83a;

  system_reset_nmi_vectors system_reset_nmi_vectors_inst (
    .clk_in, .rst_n_in, .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .reset_cause_in, .system_nmi_in, .user_nmi_in, .irq_out, .reset_pending_out,
    .system_nmi_pending_out, .user_nmi_pending_out
  );

  // 25 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(rdata_out, e)
    end
    rd_d <= rd_in && clk_en_in;
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task idle();
    rd_in <= 1'b0;
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : idle

  // Strobes stay up between calls so reads can run back to back
  task rd(input logic [15:0] a, input logic [15:0] x);
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    exp_q.push_back(x);
    @(posedge clk_in);
  endtask : rd

  task wr(input logic [15:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  // Reset group skips the reserved code after the flash key fault
  function automatic logic [15:0] code(int g, int i);
    return 16'((g == 0 && i > 12) ? 2 * i + 4 : 2 * i + 2);
  endfunction : code

  // Pulse a source mix, then drain the vector in priority order
  task grp(input int g, input logic [14:0] m);
    logic [15:0] a;
    int n;
    n = (g == 0) ? RST_N : (g == 1) ? SNMI_N : UNMI_N;
    a = (g == 0) ? RESET_CAUSE_VECTOR_ADDR :
        (g == 1) ? SYSTEM_NMI_VECTOR_ADDR : USER_NMI_VECTOR_ADDR;
    m = m & 15'((1 << n) - 1);
    // A strobe left up by the last call would be taken again here
    rd_in <= 1'b0;
    wr_in <= 1'b0;
    reset_cause_in <= (g == 0) ? m : '0;
    system_nmi_in <= (g == 1) ? m[8:0] : '0;
    user_nmi_in <= (g == 2) ? m[2:0] : '0;
    @(posedge clk_in);
    reset_cause_in <= '0;
    system_nmi_in <= '0;
    user_nmi_in <= '0;
    for (int i = 0; i < n; i++) if (m[i]) rd(a, code(g, i));
    rd(a, VEC_NONE);
    idle();
    // Drained groups drop their pending levels
    `CHK({reset_pending_out, system_nmi_pending_out, user_nmi_pending_out}, 3'b000)
  endtask : grp

  // Interrupt level looked at mid-cycle, after the edge has settled
  task chk_irq(input logic x);
    idle();
    @(negedge clk_in);
    `CHK(irq_out, x)
    @(posedge clk_in);
  endtask : chk_irq

  task finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Watchdog well past the expected run length
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    clk_en_in = 1'b1;
    rd_in = 1'b0;
    wr_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    reset_cause_in = '0;
    system_nmi_in = '0;
    user_nmi_in = '0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // every source alone, then random mixes
    for (int g = 0; g < 3; g++) for (int i = 0; i < 15; i++) grp(g, 15'(1 << i));
    repeat (20) for (int g = 0; g < 3; g++) grp(g, 15'($random(seed)));
    // Interrupt raised, cleared, then masked off
    wr(IRQ_STATUS_ADDR, 16'h0007);
    wr(IRQ_MASK_ADDR, 16'h0002);
    grp(1, 15'h0020);
    rd(IRQ_STATUS_ADDR, 16'h0002);
    rd(IRQ_MASK_ADDR, 16'h0002);
    chk_irq(1'b1);
    wr(IRQ_STATUS_ADDR, 16'h0002);
    rd(IRQ_STATUS_ADDR, VEC_NONE);
    grp(2, 15'h0001);
    rd(IRQ_STATUS_ADDR, 16'h0004);
    chk_irq(1'b0);
    // vector is read-only, unmapped reads give zero
    wr(USER_NMI_VECTOR_ADDR, 16'hFFFF);
    rd(USER_NMI_VECTOR_ADDR, VEC_NONE);
    rd(16'h0100, VEC_NONE);
    idle();
    // events ignored while the block is disabled
    clk_en_in <= 1'b0;
    reset_cause_in <= 15'h0001;
    @(posedge clk_in);
    reset_cause_in <= '0;
    clk_en_in <= 1'b1;
    rd(RESET_CAUSE_VECTOR_ADDR, VEC_NONE);
    idle();
    idle();
    finish_test();
  end
endmodule : system_reset_nmi_vectors_bench
`default_nettype wire
